// ### design/sqio_pkg.sv
// Package of constants and types for the sequence I/O allocation block
// Summary of operation
// [R1] Four output selects accept codes 0..11; new values apply after power cycle.
// [R2] Output codes: none, ready, in-position, alarm a/b, brake, limit, halt, etc.
// [R3] Output defaults: 1 ready, 2 in-position, 3 alarm active-open, 4 none.
// [R4] Input codes 0..8: none, enable, alarm clear, limits, halt, P, clear, overheat.
// [R5] Input codes 9..21: anti-resonance, pulse, mode, jog, speed, ramp, limit, freewheel.
// [R6] Rotation only while motor enable active; commands ignored otherwise.
// [R7] Enable drop while turning: max brake to zero-speed band, then coast.
// [R8] Able to rotate when enable, no alarm, both limits and halt active.
// [R9] Enable active but a limit or halt inactive holds motor stopped.
// [R10] Enable comes from code 1 terminal; unassigned means always active.
// [R11] Latched alarms clear on rising edge of alarm clear, not level.
// [R12] Alarm clear covers the eleven resettable alarm sources.
// [R13] Alarm clear comes from code 2 terminal; unassigned means never active.
// [R14] Alarm clear defaults to input terminal two.
// [R15] Alarms also clear on both keys held over one second, and power cycle.
// [R16] Five input selects accept 0..21, power-cycle change, defaults enable and clear.
// [R17] Output driven by selected status; code 0 inactive; active-open inverts alarm.
// [R18] Each input routed by its code; multiple terminals combine by OR.
package sqio_pkg;
   // Register byte addresses on APB
   localparam logic [11:0] OUT1_SEL_ADDR  = 12'h000;
   localparam logic [11:0] OUT2_SEL_ADDR  = 12'h004;
   localparam logic [11:0] OUT3_SEL_ADDR  = 12'h008;
   localparam logic [11:0] OUT4_SEL_ADDR  = 12'h00C;
   localparam logic [11:0] IN1_SEL_ADDR   = 12'h010;
   localparam logic [11:0] IN2_SEL_ADDR   = 12'h014;
   localparam logic [11:0] IN3_SEL_ADDR   = 12'h018;
   localparam logic [11:0] IN4_SEL_ADDR   = 12'h01C;
   localparam logic [11:0] IN5_SEL_ADDR   = 12'h020;
   localparam logic [11:0] STATUS_ADDR    = 12'h024;
   localparam logic [11:0] ALARM_ADDR     = 12'h028;
   // Reset values of the selects
   localparam logic [7:0] OUT1_SEL_RST = 8'h01;
   localparam logic [7:0] OUT2_SEL_RST = 8'h02;
   localparam logic [7:0] OUT3_SEL_RST = 8'h04;
   localparam logic [7:0] OUT4_SEL_RST = 8'h00;
   localparam logic [7:0] IN1_SEL_RST  = 8'h01;
   localparam logic [7:0] IN2_SEL_RST  = 8'h02;
   localparam logic [7:0] IN3_SEL_RST  = 8'h00;
   localparam logic [7:0] IN4_SEL_RST  = 8'h00;
   localparam logic [7:0] IN5_SEL_RST  = 8'h00;
   // Code ranges
   localparam logic [7:0] OUT_CODE_MAX = 8'h0B;
   localparam logic [7:0] IN_CODE_MAX  = 8'h15;
   // Input function codes
   localparam logic [4:0] IN_NONE = 5'h00;
   localparam logic [4:0] IN_ENABLE = 5'h01;
   localparam logic [4:0] IN_ALM_CLR = 5'h02;
   localparam logic [4:0] IN_FWD_LIM = 5'h03;
   localparam logic [4:0] IN_REV_LIM = 5'h04;
   localparam logic [4:0] IN_HALT = 5'h05;
   localparam logic [4:0] IN_OVERHEAT = 5'h08;
   // Output function codes
   localparam logic [3:0] OUT_NONE = 4'h0;
   localparam logic [3:0] OUT_READY = 4'h1;
   localparam logic [3:0] OUT_INPOS = 4'h2;
   localparam logic [3:0] OUT_ALM_A = 4'h3;
   localparam logic [3:0] OUT_ALM_B = 4'h4;
   localparam logic [3:0] OUT_DBRAKE = 4'h5;
   localparam logic [3:0] OUT_LIMIT = 4'h6;
   localparam logic [3:0] OUT_HALT = 4'h7;
   localparam logic [3:0] OUT_ZDEV = 4'h8;
   localparam logic [3:0] OUT_ZSPD = 4'h9;
   localparam logic [3:0] OUT_ILIM = 4'hA;
   localparam logic [3:0] OUT_BRAKE = 4'hB;
   // Counts
   localparam int NUM_IN  = 5;
   localparam int NUM_OUT = 4;
   localparam int NUM_FUNC = 22;
   localparam int NUM_ALARM = 11;
   // Key hold time and derived cycles at 250 MHz
   localparam int KEY_HOLD_MS = 1000;
   localparam int CLK_MHZ = 250;
   localparam int KEY_HOLD_CYC = KEY_HOLD_MS * 1000 * CLK_MHZ + 1;
   // Status bit positions
   localparam int ST_ENABLE = 0;
   localparam int ST_READY = 1;
   localparam int ST_HOLD = 2;
   localparam int ST_BRAKING = 3;
   localparam int ST_COAST = 4;
   localparam int ST_ALARM = 5;
   // Drive state: Gray along run, brake, coast
   typedef enum logic [1:0] {
      SQIO_OFF   = 2'b00,
      SQIO_RUN   = 2'b01,
      SQIO_BRAKE = 2'b11,
      SQIO_COAST = 2'b10
   } sqio_drive_t;
   // Status inputs from the servo core
   typedef struct packed {
      logic in_position;
      logic zero_deviation;
      logic zero_speed;
      logic current_limit;
      logic brake_timing;
      logic dyn_brake;
   } sqio_core_t;
endpackage

// ### design/sqio_top.sv
// Sequence I/O allocation, motor enable gating and alarm clear logic
`timescale 1ns/1ps
module sqio_top #(
   parameter int KEY_HOLD = sqio_pkg::KEY_HOLD_CYC
) (
   // Clock and reset
   input  wire logic                              CLK_I,
   input  wire logic                              RST_B_I,
   // APB slave
   input  wire logic                              PSEL_I,
   input  wire logic                              PENABLE_I,
   input  wire logic                              PWRITE_I,
   input  wire logic [11:0]                       PADDR_I,
   input  wire logic [31:0]                       PWDATA_I,
   output logic      [31:0]                       PRDATA_O,
   output logic                                   PREADY_O,
   output logic                                   PSLVERR_O,
   // Terminals
   input  wire logic [sqio_pkg::NUM_IN-1:0]       SEQ_IN_I,
   output logic      [sqio_pkg::NUM_OUT-1:0]      SEQ_OUT_O,
   // Panel keys and power-cycle apply strobe
   input  wire logic                              KEY_UP_I,
   input  wire logic                              KEY_DOWN_I,
   input  wire logic                              POWER_APPLY_I,
   // Servo core interface
   input  wire logic [sqio_pkg::NUM_ALARM-1:0]    ALARM_RAISE_I,
   input  wire sqio_pkg::sqio_core_t              CORE_I,
   output logic [sqio_pkg::NUM_FUNC-1:0]          FUNC_O,
   output logic                                   READY_O,
   output logic                                   HOLD_STOP_O,
   output logic                                   MAX_BRAKE_O,
   output logic                                   TORQUE_OFF_O
);
   logic [7:0] out_pend_reg [sqio_pkg::NUM_OUT];
   logic [7:0] out_sel_reg  [sqio_pkg::NUM_OUT];
   logic [7:0] in_pend_reg  [sqio_pkg::NUM_IN];
   logic [7:0] in_sel_reg   [sqio_pkg::NUM_IN];
   logic [sqio_pkg::NUM_IN-1:0]   s1_reg, s2_reg, s3_reg, in_lvl_reg;
   logic [1:0]                    k1_reg, k2_reg, k3_reg, key_reg;
   logic [sqio_pkg::NUM_ALARM-1:0] alarm_reg;
   logic [31:0]                   key_cnt_reg;
   logic                          clr_prev_reg;
   sqio_pkg::sqio_drive_t         drive_reg, drive_next;
   logic [sqio_pkg::NUM_FUNC-1:0] func_raw, func_asg;
   logic [sqio_pkg::NUM_OUT-1:0]  out_next;
   logic                          en_act, clr_act, fwd_ok, rev_ok, halt_ok;
   logic                          alarm_any, ready, clr_edge, key_clear;
   logic                          wr_en;
   logic [31:0]                   rd_data;

   localparam logic [7:0] OUT_RST [sqio_pkg::NUM_OUT] = '{sqio_pkg::OUT1_SEL_RST,
      sqio_pkg::OUT2_SEL_RST, sqio_pkg::OUT3_SEL_RST, sqio_pkg::OUT4_SEL_RST};
   localparam logic [7:0] IN_RST [sqio_pkg::NUM_IN] = '{sqio_pkg::IN1_SEL_RST,
      sqio_pkg::IN2_SEL_RST, sqio_pkg::IN3_SEL_RST, sqio_pkg::IN4_SEL_RST,
      sqio_pkg::IN5_SEL_RST}; // [R14] [R16]

   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;

   // Pending allocation settings written by software
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         for (int i = 0; i < sqio_pkg::NUM_OUT; i++) begin
            out_pend_reg[i] <= OUT_RST[i]; // [R3]
         end
         for (int i = 0; i < sqio_pkg::NUM_IN; i++) begin
            in_pend_reg[i] <= IN_RST[i];
         end
      end else if (wr_en) begin
         for (int i = 0; i < sqio_pkg::NUM_OUT; i++) begin
            if (PADDR_I == sqio_pkg::OUT1_SEL_ADDR + 12'(4 * i)
                && PWDATA_I[7:0] <= sqio_pkg::OUT_CODE_MAX) begin // [R1]
               out_pend_reg[i] <= PWDATA_I[7:0];
            end
         end
         for (int i = 0; i < sqio_pkg::NUM_IN; i++) begin
            if (PADDR_I == sqio_pkg::IN1_SEL_ADDR + 12'(4 * i)
                && PWDATA_I[7:0] <= sqio_pkg::IN_CODE_MAX) begin // [R16]
               in_pend_reg[i] <= PWDATA_I[7:0];
            end
         end
      end
   end

   // Active allocations load only on power-cycle apply
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         for (int i = 0; i < sqio_pkg::NUM_OUT; i++) begin
            out_sel_reg[i] <= OUT_RST[i];
         end
         for (int i = 0; i < sqio_pkg::NUM_IN; i++) begin
            in_sel_reg[i] <= IN_RST[i];
         end
      end else if (POWER_APPLY_I) begin
         out_sel_reg <= out_pend_reg; // [R1]
         in_sel_reg  <= in_pend_reg; // [R16]
      end
   end

   // Three-stage terminal and key synchronisers
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         s1_reg     <= '0;
         s2_reg     <= '0;
         s3_reg     <= '0;
         in_lvl_reg <= '0;
         k1_reg     <= '0;
         k2_reg     <= '0;
         k3_reg     <= '0;
         key_reg    <= '0;
      end else begin
         s1_reg <= SEQ_IN_I;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < sqio_pkg::NUM_IN; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               in_lvl_reg[i] <= s3_reg[i];
            end
         end
         k1_reg <= {KEY_UP_I, KEY_DOWN_I};
         k2_reg <= k1_reg;
         k3_reg <= k2_reg;
         for (int i = 0; i < 2; i++) begin
            if (k2_reg[i] == k3_reg[i]) begin
               key_reg[i] <= k3_reg[i];
            end
         end
      end
   end

   // Route terminals to functions, OR of all terminals with one code
   always_comb begin
      func_raw = '0;
      func_asg = '0;
      for (int i = 0; i < sqio_pkg::NUM_IN; i++) begin
         for (int f = 1; f < sqio_pkg::NUM_FUNC; f++) begin
            if (in_sel_reg[i] == 8'(f)) begin // [R4] [R5]
               func_raw[f] = func_raw[f] | in_lvl_reg[i]; // [R18]
               func_asg[f] = 1'b1;
            end
         end
      end
   end

   // Defaults for unassigned functions
   assign en_act  = func_asg[sqio_pkg::IN_ENABLE] ? func_raw[sqio_pkg::IN_ENABLE] : 1'b1; // [R10]
   assign clr_act = func_asg[sqio_pkg::IN_ALM_CLR] && func_raw[sqio_pkg::IN_ALM_CLR]; // [R13]
   assign fwd_ok  = func_asg[sqio_pkg::IN_FWD_LIM] ? func_raw[sqio_pkg::IN_FWD_LIM] : 1'b1;
   assign rev_ok  = func_asg[sqio_pkg::IN_REV_LIM] ? func_raw[sqio_pkg::IN_REV_LIM] : 1'b1;
   assign halt_ok = func_asg[sqio_pkg::IN_HALT] ? func_raw[sqio_pkg::IN_HALT] : 1'b1;
   assign alarm_any = |alarm_reg;
   assign ready   = en_act && !alarm_any && fwd_ok && rev_ok && halt_ok; // [R8]
   assign clr_edge = clr_act && !clr_prev_reg; // [R11]
   assign key_clear = (key_cnt_reg == 32'(KEY_HOLD)) && alarm_any; // [R15]

   // Alarm clear edge memory
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         clr_prev_reg <= 1'b0;
      end else begin
         clr_prev_reg <= clr_act;
      end
   end

   // Key hold timer, counts while both keys held and an alarm shows
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         key_cnt_reg <= '0;
      end else if (!(key_reg[0] && key_reg[1] && alarm_any)) begin
         key_cnt_reg <= '0;
      end else if (key_cnt_reg != 32'(KEY_HOLD)) begin
         key_cnt_reg <= key_cnt_reg + 32'h00000001; // [R15]
      end
   end

   // Latched alarms; a new raise wins over a clear
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         alarm_reg <= '0; // [R15]
      end else if (clr_edge || key_clear || POWER_APPLY_I) begin
         alarm_reg <= ALARM_RAISE_I; // [R11] [R12]
      end else begin
         alarm_reg <= alarm_reg | ALARM_RAISE_I;
      end
   end

   // Drive state machine
   always_comb begin
      drive_next = drive_reg;
      unique case (drive_reg)
         sqio_pkg::SQIO_OFF: begin
            if (en_act) begin
               drive_next = sqio_pkg::SQIO_RUN; // [R6]
            end
         end
         sqio_pkg::SQIO_RUN: begin
            if (!en_act) begin
               drive_next = CORE_I.zero_speed ? sqio_pkg::SQIO_COAST
                                              : sqio_pkg::SQIO_BRAKE; // [R7]
            end
         end
         sqio_pkg::SQIO_BRAKE: begin
            if (CORE_I.zero_speed) begin
               drive_next = sqio_pkg::SQIO_COAST; // [R7]
            end
         end
         sqio_pkg::SQIO_COAST: begin
            drive_next = sqio_pkg::SQIO_OFF;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         drive_reg <= sqio_pkg::SQIO_OFF;
      end else begin
         drive_reg <= drive_next;
      end
   end

   // Output terminal selection
   always_comb begin
      out_next = '0;
      for (int i = 0; i < sqio_pkg::NUM_OUT; i++) begin
         unique case (out_sel_reg[i][3:0]) // [R2] [R17]
            sqio_pkg::OUT_NONE:   out_next[i] = 1'b0;
            sqio_pkg::OUT_READY:  out_next[i] = ready;
            sqio_pkg::OUT_INPOS:  out_next[i] = CORE_I.in_position;
            sqio_pkg::OUT_ALM_A:  out_next[i] = alarm_any;
            sqio_pkg::OUT_ALM_B:  out_next[i] = !alarm_any;
            sqio_pkg::OUT_DBRAKE: out_next[i] = CORE_I.dyn_brake;
            sqio_pkg::OUT_LIMIT:  out_next[i] = !fwd_ok || !rev_ok;
            sqio_pkg::OUT_HALT:   out_next[i] = !halt_ok;
            sqio_pkg::OUT_ZDEV:   out_next[i] = CORE_I.zero_deviation;
            sqio_pkg::OUT_ZSPD:   out_next[i] = CORE_I.zero_speed;
            sqio_pkg::OUT_ILIM:   out_next[i] = CORE_I.current_limit;
            sqio_pkg::OUT_BRAKE:  out_next[i] = CORE_I.brake_timing;
            default:              out_next[i] = 1'b0;
         endcase
      end
   end

   // Registered outputs to the core and terminals
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         SEQ_OUT_O    <= '0;
         FUNC_O       <= '0;
         READY_O      <= 1'b0;
         HOLD_STOP_O  <= 1'b0;
         MAX_BRAKE_O  <= 1'b0;
         TORQUE_OFF_O <= 1'b1;
      end else begin
         SEQ_OUT_O    <= out_next;
         FUNC_O       <= func_raw;
         FUNC_O[sqio_pkg::IN_ENABLE] <= en_act;
         FUNC_O[sqio_pkg::IN_FWD_LIM] <= fwd_ok;
         FUNC_O[sqio_pkg::IN_REV_LIM] <= rev_ok;
         FUNC_O[sqio_pkg::IN_HALT] <= halt_ok;
         FUNC_O[sqio_pkg::IN_OVERHEAT] <= func_asg[sqio_pkg::IN_OVERHEAT]
                                          ? func_raw[sqio_pkg::IN_OVERHEAT] : 1'b1;
         READY_O      <= ready && drive_next == sqio_pkg::SQIO_RUN; // [R6] [R8]
         HOLD_STOP_O  <= en_act && !(fwd_ok && rev_ok && halt_ok); // [R9]
         MAX_BRAKE_O  <= drive_next == sqio_pkg::SQIO_BRAKE; // [R7]
         TORQUE_OFF_O <= drive_next != sqio_pkg::SQIO_RUN && drive_next != sqio_pkg::SQIO_BRAKE;
      end
   end

   // APB read mux
   always_comb begin
      rd_data = '0;
      for (int i = 0; i < sqio_pkg::NUM_OUT; i++) begin
         if (PADDR_I == sqio_pkg::OUT1_SEL_ADDR + 12'(4 * i)) begin
            rd_data = {24'h000000, out_pend_reg[i]};
         end
      end
      for (int i = 0; i < sqio_pkg::NUM_IN; i++) begin
         if (PADDR_I == sqio_pkg::IN1_SEL_ADDR + 12'(4 * i)) begin
            rd_data = {24'h000000, in_pend_reg[i]};
         end
      end
      if (PADDR_I == sqio_pkg::STATUS_ADDR) begin
         rd_data[sqio_pkg::ST_ENABLE]  = en_act;
         rd_data[sqio_pkg::ST_READY]   = ready;
         rd_data[sqio_pkg::ST_HOLD]    = HOLD_STOP_O;
         rd_data[sqio_pkg::ST_BRAKING] = drive_reg == sqio_pkg::SQIO_BRAKE;
         rd_data[sqio_pkg::ST_COAST]   = drive_reg == sqio_pkg::SQIO_COAST;
         rd_data[sqio_pkg::ST_ALARM]   = alarm_any;
      end
      if (PADDR_I == sqio_pkg::ALARM_ADDR) begin
         rd_data = {21'h000000, alarm_reg};
      end
   end

   // APB answer: zero wait states, unmapped reads zero with error
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         PRDATA_O <= '0;
      end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
         PRDATA_O <= rd_data;
      end
   end

   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && (PADDR_I[1:0] != 2'b00
                      || PADDR_I > sqio_pkg::ALARM_ADDR);
endmodule

// ### tb/sqio_top_sva.sv
// Concurrent checks on the ports of the sequence I/O block
`timescale 1ns/1ps
module sqio_top_sva #(
   parameter int KEY_HOLD = 20
) (
   // Clock, reset and strobes
   input  wire logic                           CLK_I,
   input  wire logic                           RST_B_I,
   input  wire logic                           POWER_APPLY_I,
   input  wire logic [sqio_pkg::NUM_ALARM-1:0] ALARM_RAISE_I,
   input  wire sqio_pkg::sqio_core_t           CORE_I,
   // Observed outputs
   input  wire logic [sqio_pkg::NUM_OUT-1:0]   SEQ_OUT_O,
   input  wire logic [sqio_pkg::NUM_FUNC-1:0]  FUNC_O,
   input  wire logic                           READY_O,
   input  wire logic                           HOLD_STOP_O,
   input  wire logic                           MAX_BRAKE_O,
   input  wire logic                           TORQUE_OFF_O
);
   logic       dflt_reg;
   logic [1:0] up_reg;
   logic       lim_ok;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   assign lim_ok = FUNC_O[3] && FUNC_O[4] && FUNC_O[5];
   // Factory selects rule until the first apply strobe
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         dflt_reg <= 1'b1;
      end else if (POWER_APPLY_I) begin
         dflt_reg <= 1'b0;
      end
   end
   // Cycles since reset release, saturating, masks the registered reset values
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         up_reg <= 2'h0;
      end else if (up_reg != 2'h3) begin
         up_reg <= up_reg + 2'h1;
      end
   end
   AST_READY_CAUSE: assert property (READY_O |-> FUNC_O[1] && lim_ok)
      else $error("ready without enable, limits and halt");
   AST_HOLD_CAUSE: assert property (HOLD_STOP_O |-> FUNC_O[1] && !lim_ok)
      else $error("hold without enable or with all limits active");
   AST_BRAKE_END: assert property (MAX_BRAKE_O && CORE_I.zero_speed |-> ##[1:2] !MAX_BRAKE_O)
      else $error("braking kept inside zero speed band");
   AST_COAST_AFTER: assert property ($fell(MAX_BRAKE_O) && !FUNC_O[1] |-> TORQUE_OFF_O)
      else $error("torque kept after braking ended");
   AST_BRAKE_TORQUE: assert property (MAX_BRAKE_O |-> !TORQUE_OFF_O)
      else $error("torque off while braking");
   AST_DEFAULT_OUT: assert property (dflt_reg |-> SEQ_OUT_O[0] == READY_O && !SEQ_OUT_O[3])
      else $error("default output terminals wrong");
   AST_ALARM_OUT_B: assert property (dflt_reg && |ALARM_RAISE_I |-> ##[1:2] !SEQ_OUT_O[2])
      else $error("active-open alarm terminal not opened");
   AST_DEFAULT_FUNC: assert property (dflt_reg && up_reg == 2'h3 |-> lim_ok && FUNC_O[8])
      else $error("unassigned limit, halt or overheat not active");
   // Main scenarios
   cover property (READY_O);
   cover property (HOLD_STOP_O);
   cover property ($fell(MAX_BRAKE_O));
endmodule
bind sqio_top sqio_top_sva #(.KEY_HOLD(KEY_HOLD)) u_sva (
   .CLK_I(CLK_I), .RST_B_I(RST_B_I), .POWER_APPLY_I(POWER_APPLY_I),
   .ALARM_RAISE_I(ALARM_RAISE_I), .CORE_I(CORE_I), .SEQ_OUT_O(SEQ_OUT_O), .FUNC_O(FUNC_O),
   .READY_O(READY_O), .HOLD_STOP_O(HOLD_STOP_O), .MAX_BRAKE_O(MAX_BRAKE_O),
   .TORQUE_OFF_O(TORQUE_OFF_O)
);

// ### tb/sqio_term_ctrl.sv
// Sequence controller model that drives the five input terminals
`timescale 1ns/1ps
module sqio_term_ctrl (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic [4:0] want_i,
   output logic      [4:0] level_o
);
   logic [4:0] dly_reg [3];
   // A slow controller lags its commands by three clocks
   always_ff @(posedge clk_i) begin
      dly_reg[0] <= want_i;
      dly_reg[1] <= dly_reg[0];
      dly_reg[2] <= dly_reg[1];
   end
   // Terminals are always driven, never released
   assign level_o = slow_i ? dly_reg[2] : want_i;
endmodule

// ### tb/sqio_top_bench.sv
// Self-checking bench for the sequence I/O block
`timescale 1ns/1ps
module sqio_top_bench;
   localparam int KH = 20;
   typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} sqio_note_t;
   logic                 clk = 1'b0;
   logic                 rst_b = 1'b0;
   logic                 psel = 1'b0;
   logic                 pen = 1'b0;
   logic                 pwr = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [4:0]           term_want = 5'h00;
   logic [4:0]           seq_in;
   logic                 slow = 1'b0;
   logic [3:0]           seq_out;
   logic                 key_up = 1'b0;
   logic                 key_dn = 1'b0;
   logic                 pwr_apply = 1'b0;
   logic [10:0]          alm = 11'h000;
   logic [10:0]          av;
   sqio_pkg::sqio_core_t core = '0;
   logic [21:0]          func;
   logic                 ready, hold, brake, toff;
   logic [15:0]          lfsr = 16'h9E8B;
   logic [7:0]           dflt [9] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00};
   sqio_note_t           notes [$];
   sqio_note_t           nt;
   int                   fails = 0;
   int                   num_checks = 0;
   // Clock of 4 ns
   always #2 clk = ~clk;
   sqio_top #(.KEY_HOLD(KH)) dut (
      .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .SEQ_IN_I(seq_in), .SEQ_OUT_O(seq_out), .KEY_UP_I(key_up),
      .KEY_DOWN_I(key_dn), .POWER_APPLY_I(pwr_apply), .ALARM_RAISE_I(alm), .CORE_I(core),
      .FUNC_O(func), .READY_O(ready), .HOLD_STOP_O(hold), .MAX_BRAKE_O(brake),
      .TORQUE_OFF_O(toff)
   );
   sqio_term_ctrl u_ctrl (.clk_i(clk), .slow_i(slow), .want_i(term_want), .level_o(seq_in));
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic close_out();
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   // One APB transfer; a read leaves its expectation in the queue first
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
      int n;
      n = 0;
      if (!w) notes.push_back('{d, m, e});
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         close_out();
      end
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
      apb(1'b0, a, x, m, 1'b0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic raise();
      lfsr = step(lfsr);
      av = lfsr[10:0] | 11'h001;
      @(posedge clk);
      alm <= av;
      @(posedge clk);
      alm <= 11'h000;
      tick(4);
   endtask
   task automatic apply();
      @(posedge clk);
      pwr_apply <= 1'b1;
      @(posedge clk);
      pwr_apply <= 1'b0;
      tick(10);
   endtask
   // Completed reads are matched against the oldest note
   always @(posedge clk) begin
      if (psel && pen && pready === 1'b1 && !pwr) begin
         nt = notes.pop_front();
         chk("prdata", prdata & nt.mask, nt.data & nt.mask);
         chk("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
      end
   end
   // Main sequence
   initial begin
      tick(10);
      rst_b <= 1'b1;
      for (int i = 0; i < 9; i++) rd(12'(4 * i), {24'h0, dflt[i]}, 32'hFF);
      apb(1'b0, 12'h02C, 32'h0, 32'hFFFFFFFF, 1'b1);
      term_want <= 5'h01;
      tick(10);
      rd(12'h024, 32'h3, 32'h7);
      chk("seq_out", {28'h0, seq_out}, 32'h5);
      raise();
      rd(12'h028, {21'h0, av}, 32'h7FF);
      chk("seq_out", {28'h0, seq_out}, 32'h0);
      rd(12'h024, 32'h20, 32'h22);
      term_want <= 5'h03;
      tick(10);
      rd(12'h028, 32'h0, 32'h7FF);
      raise();
      rd(12'h028, {21'h0, av}, 32'h7FF);
      term_want <= 5'h01;
      tick(10);
      rd(12'h028, {21'h0, av}, 32'h7FF);
      key_up <= 1'b1;
      key_dn <= 1'b1;
      tick(5);
      key_up <= 1'b0;
      key_dn <= 1'b0;
      tick(5);
      rd(12'h028, {21'h0, av}, 32'h7FF);
      key_up <= 1'b1;
      key_dn <= 1'b1;
      tick(KH + 12);
      key_up <= 1'b0;
      key_dn <= 1'b0;
      tick(5);
      rd(12'h028, 32'h0, 32'h7FF);
      term_want <= 5'h00;
      tick(10);
      rd(12'h024, 32'h8, 32'hB);
      core.zero_speed <= 1'b1;
      tick(4);
      rd(12'h024, 32'h0, 32'h8);
      chk("torque_off", {31'h0, toff}, 32'h1);
      lfsr = step(lfsr);
      wr(12'h00C, 32'hC + {29'h0, lfsr[2:0]});
      rd(12'h00C, 32'h0, 32'hFF);
      wr(12'h018, 32'h16);
      rd(12'h018, 32'h0, 32'hFF);
      wr(12'h00C, 32'h3);
      wr(12'h018, 32'h3);
      wr(12'h01C, 32'h4);
      wr(12'h020, 32'h5);
      rd(12'h00C, 32'h3, 32'hFF);
      term_want <= 5'h1D;
      tick(10);
      chk("seq_out", {28'h0, seq_out}, 32'h5);
      apply();
      rd(12'h024, 32'h3, 32'h7);
      chk("seq_out", {28'h0, seq_out}, 32'h5);
      chk("func", {10'h0, func}, 32'h13A);
      term_want <= 5'h0D;
      tick(10);
      rd(12'h024, 32'h5, 32'h7);
      raise();
      chk("seq_out", {28'h0, seq_out}, 32'h8);
      wr(12'h010, 32'h0);
      wr(12'h014, 32'h0);
      apply();
      slow <= 1'b1;
      term_want <= 5'h1C;
      tick(14);
      rd(12'h024, 32'h3, 32'h7);
      raise();
      term_want <= 5'h1E;
      tick(14);
      rd(12'h028, {21'h0, av}, 32'h7FF);
      close_out();
   end
endmodule
